/* File: oscs_regs.svh */
`ifndef OSCS_REGS_SVH
`define OSCS_REGS_SVH

// Register byte offsets
`define OSCS_ADDR_W 5
`define OSCS_OFF_ENABLE 5'h00
`define OSCS_OFF_XT_CFG 5'h04
`define OSCS_OFF_HS_CFG 5'h08
`define OSCS_OFF_GUARD 5'h0c
`define OSCS_OFF_FLAGS 5'h10
`define OSCS_OFF_IRQ_EN 5'h14
`define OSCS_OFF_STATUS 5'h18

// Enable register fields
`define OSCS_EN_FAST 0
`define OSCS_EN_XT 1
`define OSCS_EN_HS 2
`define OSCS_EN_EXT 3
`define OSCS_ENABLE_RST 4'h1

// Flag and interrupt enable fields
`define OSCS_FL_FAST 0
`define OSCS_FL_XT 1
`define OSCS_FL_HS 2

// Crystal configuration fields
`define OSCS_XT_WAIT_LSB 0
`define OSCS_XT_WAIT_MSB 1
`define OSCS_XT_GAINN_LSB 2
`define OSCS_XT_GAINN_MSB 3
`define OSCS_XT_CAP_LSB 4
`define OSCS_XT_CAP_MSB 6
`define OSCS_XT_GAINB_LSB 8
`define OSCS_XT_GAINB_MSB 9
`define OSCS_XT_BOOST 10
`define OSCS_XT_RESTART 11
`define OSCS_XT_CFG_W 12
`define OSCS_XT_CFG_RST 12'h000

// High-speed configuration fields
`define OSCS_HS_WAIT_LSB 0
`define OSCS_HS_WAIT_MSB 2
`define OSCS_HS_TYPE_LSB 4
`define OSCS_HS_TYPE_MSB 5
`define OSCS_HS_FREQ_LSB 6
`define OSCS_HS_FREQ_MSB 7
`define OSCS_HS_CFG_W 8
`define OSCS_HS_CFG_RST 8'h00

// Write guard
`define OSCS_GUARD_KEY 16'h0096
`define OSCS_GUARD_RST 16'h0000

// Wait lengths in oscillator cycles
`define OSCS_CNT_W 17
`define OSCS_FAST_WAIT 17'h00010
`define OSCS_XT_WAIT0 17'h01000
`define OSCS_XT_WAIT1 17'h04000
`define OSCS_XT_WAIT2 17'h08000
`define OSCS_XT_WAIT3 17'h10000
`define OSCS_HS_WAIT0 17'h00004
`define OSCS_HS_WAIT1 17'h00010
`define OSCS_HS_WAIT2 17'h00040
`define OSCS_HS_WAIT3 17'h00100
`define OSCS_HS_WAIT4 17'h00400
`define OSCS_HS_WAIT5 17'h01000
`define OSCS_HS_WAIT6 17'h04000
`define OSCS_HS_WAIT7 17'h10000

// System clock source code of the fast internal oscillator
`define OSCS_SRC_FAST 2'h0

`endif

/* File: oscs_pkg.sv */
package oscs_pkg;

    typedef enum logic [1:0] {
        OSCS_HS_CRYSTAL = 2'b00,
        OSCS_HS_RC = 2'b01,
        OSCS_HS_INTERNAL = 2'b10
    } oscs_hs_type_t;

    typedef enum logic [1:0] {
        OSCS_RESP_OKAY = 2'b00,
        OSCS_RESP_SLVERR = 2'b10
    } oscs_resp_t;

endpackage

/* File: oscs_wait_cnt.sv */
`timescale 1ns/1ps
module oscs_wait_cnt
    import oscs_pkg::*;
#(
    parameter int CNT_W = 17
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic osc_clk_i,
    input wire logic [CNT_W-1:0] target_i,
    output logic edge_o,
    output logic done_o,
    output logic done_pulse_o
);

    logic osc_prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_inc;
    logic done_q;
    logic pulse_q;
    logic hit;

    assign edge_o = osc_clk_i & ~osc_prev_q;
    assign cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    assign hit = edge_o & ~done_q & (cnt_inc >= target_i);
    assign done_o = done_q;
    assign done_pulse_o = pulse_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            osc_prev_q <= 1'b0;
        else
            osc_prev_q <= osc_clk_i;
    end

    // Stopping the source discards progress: every start waits in full
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !run_i)
        begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        else if (edge_o && !done_q)
        begin
            cnt_q <= cnt_inc;
            done_q <= hit;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            pulse_q <= 1'b0;
        else
            pulse_q <= hit & run_i;
    end

endmodule

/* File: oscs_stop_det.sv */
`timescale 1ns/1ps
module oscs_stop_det
    import oscs_pkg::*;
#(
    parameter int STOP_LIMIT = 4096
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic arm_i,
    input wire logic osc_edge_i,
    output logic stop_o
);

    localparam int LIM_W = $clog2(STOP_LIMIT + 1);
    localparam logic [LIM_W-1:0] LIM = LIM_W'(STOP_LIMIT);

    logic [LIM_W-1:0] gap_q;
    logic stop_q;

    assign stop_o = stop_q;

    // Counts system cycles since the last oscillator edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !arm_i || osc_edge_i)
            gap_q <= '0;
        else if (gap_q != LIM)
            gap_q <= gap_q + {{(LIM_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            stop_q <= 1'b0;
        else
            stop_q <= arm_i & ~osc_edge_i
                & (gap_q == LIM - {{(LIM_W-1){1'b0}}, 1'b1});
    end

endmodule

/* File: oscs_ctrl.sv */
`timescale 1ns/1ps
`include "oscs_regs.svh"

// Behaviour
// - After reset the system clock source is the fast internal oscillator.
// - Fast internal oscillator waits a fixed 16 of its own cycles.
// - Crystal wait picked by 2-bit field, high-speed wait by 3-bit field.
// - An oscillator's clock stays gated while its wait is still counting.
// - Wait end opens the clock; the ready flag sets one cycle later.
// - Every oscillation start counts the full wait regardless of flag.
// - Writing 1 clears a ready flag; writing 0 leaves it.
// - Each flag has an enable; interrupt asserts while both are 1.
// - Writing 1 to an enable bit starts oscillator and its wait (no wait for external).
// - Crystal configuration writable only after key 0x0096 is written.
// - Any other key value restores protection of the configuration.
// - Crystal config holds normal gain, gate capacitor and boost gain.
// - With boost set, boost gain applies for fixed period after enable.
// - High-speed type selectable: crystal/ceramic, RC or internal.
// - Internal high-speed type frequency comes from a writable field.
// - Crystal stop detector notices lost oscillation and restarts it.
// - High-speed config holds 2-bit type, 2-bit frequency, 3-bit wait.
module oscs_ctrl
    import oscs_pkg::*;
#(
    parameter int BOOST_EDGES = 1024,
    parameter int STOP_LIMIT = 4096
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [`OSCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`OSCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fast_internal_clk_i,
    input wire logic crystal_32k_clk_i,
    input wire logic high_speed_clk_i,
    output logic fast_internal_en_o,
    output logic crystal_osc_en_o,
    output logic high_speed_en_o,
    output logic ext_clock_en_o,
    output logic fast_internal_gate_o,
    output logic crystal_gate_o,
    output logic high_speed_gate_o,
    output logic ext_clock_gate_o,
    output logic [1:0] system_clk_src_o,
    output logic [1:0] crystal_gain_o,
    output logic [2:0] crystal_gate_cap_o,
    output logic [1:0] high_speed_type_o,
    output logic [1:0] high_speed_freq_o,
    output logic clock_irq_o
);

    localparam int BW = $clog2(BOOST_EDGES + 1);
    localparam logic [BW-1:0] BLIM = BW'(BOOST_EDGES);

    logic [3:0] enable_q;
    logic [`OSCS_XT_CFG_W-1:0] xt_cfg_q;
    logic [`OSCS_HS_CFG_W-1:0] hs_cfg_q;
    logic [15:0] guard_q;
    logic [2:0] flags_q;
    logic [2:0] irq_en_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [BW-1:0] boost_cnt_q;
    logic [1:0] gain_q;
    logic restart_q;

    logic wr_go;
    logic rd_go;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic unlocked;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [2:0] w1c;
    logic [2:0] set_pulse;
    logic [2:0] done;
    logic xt_run;
    logic xt_edge;
    logic xt_stop;
    logic boost_on;
    logic [`OSCS_CNT_W-1:0] xt_target;
    logic [`OSCS_CNT_W-1:0] hs_target;

    // Both channels are taken in the same cycle; the response follows
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign rd_go = s_axi_arvalid & ~rvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mask
            assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
        end
    endgenerate

    assign unlocked = (guard_q == `OSCS_GUARD_KEY);

    always_comb
    begin
        wr_hit = 1'b1;
        unique case (s_axi_awaddr)
            `OSCS_OFF_ENABLE, `OSCS_OFF_XT_CFG, `OSCS_OFF_HS_CFG,
            `OSCS_OFF_GUARD, `OSCS_OFF_FLAGS, `OSCS_OFF_IRQ_EN,
            `OSCS_OFF_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    assign wval = s_axi_wdata & wmask;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            enable_q <= `OSCS_ENABLE_RST;
        else if (wr_go && s_axi_awaddr == `OSCS_OFF_ENABLE)
            enable_q <= (enable_q & ~wmask[3:0]) | wval[3:0];
    end

    // Guarded configuration: writes are dropped while locked
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            xt_cfg_q <= `OSCS_XT_CFG_RST;
        else if (wr_go && unlocked && s_axi_awaddr == `OSCS_OFF_XT_CFG)
            xt_cfg_q <= (xt_cfg_q & ~wmask[`OSCS_XT_CFG_W-1:0])
                        | wval[`OSCS_XT_CFG_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            hs_cfg_q <= `OSCS_HS_CFG_RST;
        else if (wr_go && unlocked && s_axi_awaddr == `OSCS_OFF_HS_CFG)
            hs_cfg_q <= (hs_cfg_q & ~wmask[`OSCS_HS_CFG_W-1:0])
                        | wval[`OSCS_HS_CFG_W-1:0];
    end

    // Any value other than the key relocks
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            guard_q <= `OSCS_GUARD_RST;
        else if (wr_go && s_axi_awaddr == `OSCS_OFF_GUARD)
            guard_q <= (guard_q & ~wmask[15:0])
                       | wval[15:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            irq_en_q <= 3'h0;
        else if (wr_go && s_axi_awaddr == `OSCS_OFF_IRQ_EN)
            irq_en_q <= (irq_en_q & ~wmask[2:0]) | wval[2:0];
    end

    assign w1c = (wr_go && s_axi_awaddr == `OSCS_OFF_FLAGS) ?
                 wval[2:0] : 3'h0;

    // Set beats a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            flags_q <= 3'h0;
        else
            flags_q <= (flags_q & ~w1c) | set_pulse;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= OSCS_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? OSCS_RESP_OKAY : OSCS_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_comb
    begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `OSCS_OFF_ENABLE: rd_word = {28'h0, enable_q};
            `OSCS_OFF_XT_CFG: rd_word = {20'h0, xt_cfg_q};
            `OSCS_OFF_HS_CFG: rd_word = {24'h0, hs_cfg_q};
            `OSCS_OFF_GUARD: rd_word = {31'h0, unlocked};
            `OSCS_OFF_FLAGS: rd_word = {29'h0, flags_q};
            `OSCS_OFF_IRQ_EN: rd_word = {29'h0, irq_en_q};
            `OSCS_OFF_STATUS: rd_word = {26'h0, boost_on, xt_run,
                                         ext_clock_gate_o, done};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= OSCS_RESP_OKAY;
            rdata_q <= 32'h0;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? OSCS_RESP_OKAY : OSCS_RESP_SLVERR;
            rdata_q <= rd_word;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    always_comb
    begin
        unique case (xt_cfg_q[`OSCS_XT_WAIT_MSB:`OSCS_XT_WAIT_LSB])
            2'h0: xt_target = `OSCS_XT_WAIT0;
            2'h1: xt_target = `OSCS_XT_WAIT1;
            2'h2: xt_target = `OSCS_XT_WAIT2;
            2'h3: xt_target = `OSCS_XT_WAIT3;
        endcase
    end

    always_comb
    begin
        unique case (hs_cfg_q[`OSCS_HS_WAIT_MSB:`OSCS_HS_WAIT_LSB])
            3'h0: hs_target = `OSCS_HS_WAIT0;
            3'h1: hs_target = `OSCS_HS_WAIT1;
            3'h2: hs_target = `OSCS_HS_WAIT2;
            3'h3: hs_target = `OSCS_HS_WAIT3;
            3'h4: hs_target = `OSCS_HS_WAIT4;
            3'h5: hs_target = `OSCS_HS_WAIT5;
            3'h6: hs_target = `OSCS_HS_WAIT6;
            3'h7: hs_target = `OSCS_HS_WAIT7;
        endcase
    end

    // A detected stop drops the crystal for one cycle to restart it
    assign xt_run = enable_q[`OSCS_EN_XT] & ~restart_q;

    oscs_wait_cnt #(.CNT_W(`OSCS_CNT_W)) u_fast_wait (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(enable_q[`OSCS_EN_FAST]),
        .osc_clk_i(fast_internal_clk_i),
        .target_i(`OSCS_FAST_WAIT),
        .edge_o(),
        .done_o(done[`OSCS_FL_FAST]),
        .done_pulse_o(set_pulse[`OSCS_FL_FAST])
    );

    oscs_wait_cnt #(.CNT_W(`OSCS_CNT_W)) u_xt_wait (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(xt_run),
        .osc_clk_i(crystal_32k_clk_i),
        .target_i(xt_target),
        .edge_o(xt_edge),
        .done_o(done[`OSCS_FL_XT]),
        .done_pulse_o(set_pulse[`OSCS_FL_XT])
    );

    oscs_wait_cnt #(.CNT_W(`OSCS_CNT_W)) u_hs_wait (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(enable_q[`OSCS_EN_HS]),
        .osc_clk_i(high_speed_clk_i),
        .target_i(hs_target),
        .edge_o(),
        .done_o(done[`OSCS_FL_HS]),
        .done_pulse_o(set_pulse[`OSCS_FL_HS])
    );

    oscs_stop_det #(.STOP_LIMIT(STOP_LIMIT)) u_xt_stop (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .arm_i(xt_run & done[`OSCS_FL_XT] & xt_cfg_q[`OSCS_XT_RESTART]),
        .osc_edge_i(xt_edge),
        .stop_o(xt_stop)
    );

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            restart_q <= 1'b0;
        else
            restart_q <= xt_stop;
    end

    // Boost period counts crystal edges from the start of oscillation
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !xt_run)
            boost_cnt_q <= '0;
        else if (xt_edge && boost_cnt_q != BLIM)
            boost_cnt_q <= boost_cnt_q + {{(BW-1){1'b0}}, 1'b1};
    end

    assign boost_on = xt_run & xt_cfg_q[`OSCS_XT_BOOST]
                      & (boost_cnt_q != BLIM);

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            gain_q <= 2'h0;
        else if (boost_on)
            gain_q <= xt_cfg_q[`OSCS_XT_GAINB_MSB:`OSCS_XT_GAINB_LSB];
        else
            gain_q <= xt_cfg_q[`OSCS_XT_GAINN_MSB:`OSCS_XT_GAINN_LSB];
    end

    assign fast_internal_en_o = enable_q[`OSCS_EN_FAST];
    assign crystal_osc_en_o = xt_run;
    assign high_speed_en_o = enable_q[`OSCS_EN_HS];
    assign ext_clock_en_o = enable_q[`OSCS_EN_EXT];
    // Clocks pass only after their wait
    assign fast_internal_gate_o = done[`OSCS_FL_FAST];
    assign crystal_gate_o = done[`OSCS_FL_XT];
    assign high_speed_gate_o = done[`OSCS_FL_HS];
    // No wait stage for the external input
    assign ext_clock_gate_o = enable_q[`OSCS_EN_EXT];
    assign system_clk_src_o = `OSCS_SRC_FAST;
    assign crystal_gain_o = gain_q;
    assign crystal_gate_cap_o = xt_cfg_q[`OSCS_XT_CAP_MSB:`OSCS_XT_CAP_LSB];
    assign high_speed_type_o =
        hs_cfg_q[`OSCS_HS_TYPE_MSB:`OSCS_HS_TYPE_LSB];
    assign high_speed_freq_o =
        hs_cfg_q[`OSCS_HS_FREQ_MSB:`OSCS_HS_FREQ_LSB];
    assign clock_irq_o = |(flags_q & irq_en_q);

endmodule

/* File: oscs_ctrl_asserts.sv */
`timescale 1ns/1ps
module oscs_ctrl_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic fast_internal_en_o,
    input wire logic crystal_osc_en_o,
    input wire logic high_speed_en_o,
    input wire logic ext_clock_en_o,
    input wire logic fast_internal_gate_o,
    input wire logic crystal_gate_o,
    input wire logic high_speed_gate_o,
    input wire logic ext_clock_gate_o,
    input wire logic [1:0] system_clk_src_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_boot_src: assert property (system_clk_src_o == 2'h0)
        else $error("System clock left the boot oscillator");
    a_boot_en: assert property ($rose(rst_b_i) |->
        fast_internal_en_o)
        else $error("Boot oscillator not enabled after reset");
    a_ext_gate: assert property (ext_clock_gate_o ==
        ext_clock_en_o)
        else $error("External clock gate differs from its enable");
    a_fast_off: assert property (!fast_internal_en_o |=>
        !fast_internal_gate_o)
        else $error("Fast clock still released after disable");
    a_xt_off: assert property (!crystal_osc_en_o |=>
        !crystal_gate_o)
        else $error("Crystal clock still released after disable");
    a_hs_off: assert property (!high_speed_en_o |=>
        !high_speed_gate_o)
        else $error("High-speed clock still released after disable");
    a_fast_wait: assert property ($rose(fast_internal_gate_o) |->
        $past(fast_internal_en_o, 30))
        else $error("Fast clock released before its wait ended");
    a_hs_wait: assert property ($rose(high_speed_gate_o) |->
        $past(high_speed_en_o, 6))
        else $error("High-speed clock released before its wait ended");
    a_b_answer: assert property (s_axi_awvalid && s_axi_wvalid &&
        !s_axi_bvalid |=> s_axi_bvalid)
        else $error("Write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before bready");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped before rready");
endmodule

bind oscs_ctrl oscs_ctrl_asserts u_chk (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .fast_internal_en_o(fast_internal_en_o),
    .crystal_osc_en_o(crystal_osc_en_o),
    .high_speed_en_o(high_speed_en_o),
    .ext_clock_en_o(ext_clock_en_o),
    .fast_internal_gate_o(fast_internal_gate_o),
    .crystal_gate_o(crystal_gate_o),
    .high_speed_gate_o(high_speed_gate_o),
    .ext_clock_gate_o(ext_clock_gate_o),
    .system_clk_src_o(system_clk_src_o)
);

/* File: testbench.sv */
`timescale 1ns/1ps
`include "oscs_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
    import oscs_pkg::*;
;
    localparam logic [1:0] OK = OSCS_RESP_OKAY;
    localparam logic [1:0] ER = OSCS_RESP_SLVERR;
    logic clk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, r, g, xp;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, src, gain, htype, hfreq;
    logic [2:0] osc, cap;
    logic [7:0] h;
    logic fen, xen, hen, een, fg, xg, hg, eg, irq;
    int num_errors, n_compared;

    oscs_ctrl #(.BOOST_EDGES(4), .STOP_LIMIT(16)) DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fast_internal_clk_i(osc[0]), .crystal_32k_clk_i(osc[1]),
        .high_speed_clk_i(osc[2]), .fast_internal_en_o(fen),
        .crystal_osc_en_o(xen), .high_speed_en_o(hen),
        .ext_clock_en_o(een), .fast_internal_gate_o(fg),
        .crystal_gate_o(xg), .high_speed_gate_o(hg), .ext_clock_gate_o(eg),
        .system_clk_src_o(src), .crystal_gain_o(gain),
        .crystal_gate_cap_o(cap), .high_speed_type_o(htype),
        .high_speed_freq_o(hfreq), .clock_irq_o(irq)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] xt_exp(input logic [31:0] v);
        return v & 32'h00000fff;
    endfunction

    task automatic close_out();
        $display("TB: compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk_i); while (!(awready && wready));
        @(posedge clk_i);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk_i); while (!bvalid);
        `CHK(bresp, er)
        @(posedge clk_i);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_i); while (!arready);
        @(posedge clk_i);
        arvalid <= 1'b0;
        do @(negedge clk_i); while (!rvalid);
        `CHK(rdata, ed)
        `CHK(rresp, er)
        @(posedge clk_i);
        rready <= 1'b0;
    endtask

    task automatic edges(input int i, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            osc[i] <= 1'b1;
            repeat (2) @(posedge clk_i);
            osc[i] <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    initial
    begin
        repeat (80000) @(posedge clk_i);
        num_errors++;
        close_out();
    end

    initial
    begin
        {rst_b_i, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, osc} = '0;
        wstrb = 4'hf;
        seed = 32'h13d9;
        num_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        `CHK(src, `OSCS_SRC_FAST)
        rd(`OSCS_OFF_ENABLE, 32'h1, OK);
        rd(`OSCS_OFF_XT_CFG, 32'h0, OK);
        rd(`OSCS_OFF_HS_CFG, 32'h0, OK);
        rd(`OSCS_OFF_FLAGS, 32'h0, OK);
        $display("TB: reset test done");
        wr(`OSCS_OFF_IRQ_EN, 32'h1, OK);
        edges(0, 15);
        settle(3);
        `CHK(fg, 1'b0)
        `CHK(irq, 1'b0)
        edges(0, 1);
        settle(3);
        `CHK(fg, 1'b1)
        `CHK(irq, 1'b1)
        rd(`OSCS_OFF_FLAGS, 32'h1, OK);
        wr(`OSCS_OFF_IRQ_EN, 32'h0, OK);
        `CHK(irq, 1'b0)
        wr(`OSCS_OFF_ENABLE, 32'h0, OK);
        settle(2);
        `CHK(fg, 1'b0)
        wr(`OSCS_OFF_ENABLE, 32'h1, OK);
        edges(0, 15);
        settle(3);
        `CHK(fg, 1'b0)
        edges(0, 1);
        settle(3);
        `CHK(fg, 1'b1)
        wr(`OSCS_OFF_FLAGS, 32'h0, OK);
        rd(`OSCS_OFF_FLAGS, 32'h1, OK);
        wr(`OSCS_OFF_FLAGS, 32'h1, OK);
        rd(`OSCS_OFF_FLAGS, 32'h0, OK);
        $display("TB: fast wait test done");
        xp = 32'h0;
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            h = r[7:0] & 8'hf7;
            if (h[5:4] == 2'b11)
                h[5:4] = 2'b10;
            wr(`OSCS_OFF_XT_CFG, r, OK);
            rd(`OSCS_OFF_XT_CFG, xp, OK);
            wr(`OSCS_OFF_GUARD, {16'h0, `OSCS_GUARD_KEY}, OK);
            rd(`OSCS_OFF_GUARD, 32'h1, OK);
            wr(`OSCS_OFF_XT_CFG, r, OK);
            wr(`OSCS_OFF_HS_CFG, {24'h0, h}, OK);
            rd(`OSCS_OFF_XT_CFG, xt_exp(r), OK);
            rd(`OSCS_OFF_HS_CFG, {24'h0, h}, OK);
            `CHK(cap, r[6:4])
            `CHK(gain, r[3:2])
            `CHK(htype, h[5:4])
            `CHK(hfreq, h[7:6])
            g = rnd();
            if (g[15:0] == `OSCS_GUARD_KEY)
                g[0] = ~g[0];
            wr(`OSCS_OFF_GUARD, g, OK);
            rd(`OSCS_OFF_GUARD, 32'h0, OK);
            xp = xt_exp(r);
            wr(`OSCS_OFF_XT_CFG, ~r, OK);
            rd(`OSCS_OFF_XT_CFG, xp, OK);
        end
        $display("TB: guard test done");
        wr(`OSCS_OFF_GUARD, {16'h0, `OSCS_GUARD_KEY}, OK);
        wr(`OSCS_OFF_HS_CFG, 32'h10, OK);
        wr(`OSCS_OFF_GUARD, 32'h0, OK);
        wr(`OSCS_OFF_ENABLE, 32'h5, OK);
        edges(2, 3);
        settle(3);
        `CHK(hg, 1'b0)
        edges(2, 1);
        settle(3);
        `CHK(hg, 1'b1)
        rd(`OSCS_OFF_STATUS, 32'h5, OK);
        wr(`OSCS_OFF_ENABLE, 32'h9, OK);
        settle(2);
        `CHK(hg, 1'b0)
        `CHK(eg, 1'b1)
        $display("TB: high-speed test done");
        wr(`OSCS_OFF_GUARD, {16'h0, `OSCS_GUARD_KEY}, OK);
        wr(`OSCS_OFF_XT_CFG, 32'he05, OK);
        wr(`OSCS_OFF_GUARD, 32'h0, OK);
        wr(`OSCS_OFF_FLAGS, 32'h7, OK);
        wr(`OSCS_OFF_IRQ_EN, 32'h2, OK);
        wr(`OSCS_OFF_ENABLE, 32'h3, OK);
        settle(1);
        `CHK({fen, xen, hen, een}, 4'hc)
        `CHK(gain, 2'h2)
        edges(1, 4);
        `CHK(gain, 2'h1)
        edges(1, 16379);
        settle(3);
        `CHK(xg, 1'b0)
        edges(1, 1);
        settle(3);
        `CHK({xg, irq}, 2'h3)
        rd(`OSCS_OFF_FLAGS, 32'h2, OK);
        settle(20);
        `CHK({xg, xen}, 2'h1)
        $display("TB: crystal test done");
        wr(5'h1c, rnd(), ER);
        rd(5'h1c, 32'h0, ER);
        wr(5'h02, rnd(), ER);
        rd(5'h06, 32'h0, ER);
        $display("TB: unmapped test done");
        close_out();
    end
endmodule
